// [rtl/ecp_defines.vh]
// Purpose: constants for the extended port control logic
// Assumes: included by bare name from rtl files
// Notes:   field positions, mode codes, reset values and default sizes only
`ifndef ECP_DEFINES_VH
`define ECP_DEFINES_VH

// extended_port_control field positions
`define EPC_MODE_HI        7
`define EPC_MODE_LO        5
`define EPC_FAULT_DIS_BIT  4
`define EPC_DMA_BIT        3
`define EPC_SVC_BIT        2
`define EPC_FULL_BIT       1
`define EPC_EMPTY_BIT      0

// mode field codes
`define MODE_COMPAT        3'h0
`define MODE_BIDIR         3'h1
`define MODE_COMPAT_FIFO   3'h2
`define MODE_ECP           3'h3
`define MODE_RSVD_A        3'h4
`define MODE_RSVD_B        3'h5
`define MODE_FIFO_TEST     3'h6
`define MODE_CONFIG        3'h7

// reset values and default sizes
`define EPC_RESET_MODE     3'h0
`define EPC_RESET_FLAG     1'h0
`define THRESH_RESET       4'h8
`define FIFO_DEPTH_DEF     16
`define FIFO_CNT_W_DEF     5
`define THRESH_W_DEF       4

`endif

// [rtl/fault_irq_detect.v]
// Purpose: error-line interrupt detector for the extended port
// Assumes: err_n_in synchronous to clk_in, active low
// Notes:   pending flag is sticky until clear_in; a new event wins
`timescale 1ns/1ps
module fault_irq_detect
(
   input  wire clk_in,
   input  wire reset_in,
   input  wire err_n_in,
   input  wire disable_in,
   input  wire clear_in,
   output wire pend_out
);

   reg err_n_q;
   reg disable_q;
   reg pend_q;
   wire fall_evt;
   wire unmask_evt;

   // falling edge of the error line while enabled
   assign fall_evt   = err_n_q & ~err_n_in & ~disable_in;
   // unmasking with error already low must not be missed
   assign unmask_evt = disable_q & ~disable_in & ~err_n_in;
   assign pend_out   = pend_q;

   // history registers and sticky pending, set beats clear
   always @(posedge clk_in)
   begin
      if (reset_in)
      begin
         err_n_q   <= 1'h1;
         disable_q <= 1'h0;
         pend_q    <= 1'h0;
      end
      else
      begin
         err_n_q   <= err_n_in;
         disable_q <= disable_in;
         if (fall_evt | unmask_evt)
            pend_q <= 1'h1;
         else if (clear_in)
            pend_q <= 1'h0;
      end
   end

endmodule // fault_irq_detect

// [rtl/ecp_extended_control_logic.v]
// Purpose: extended control register and mode/interrupt control of an
//          ecp parallel port with fifo
// Assumes: host strobes and all pin inputs synchronous to clk_in;
//          fifo datapath and 1284 handshake timing live outside
// Notes:   mode changes out of a forward auto mode take one extra
//          cycle so the control lines are negated first
// Operation
// - mode 110 lets host use fifo, never drives fifo data on lines
// - mode 111 opens configuration registers a and b to the host
// - negotiation done in modes 000/001; hardware handshakes only in transfer
// - writing mode 011 or 010 starts hardware transfer at once
// - from 000/001 any mode; otherwise only 000 or 001 accepted
// - direction and threshold change only while mode is 000/001
// - switching to 000/001 resets fifo and clears fifo error
// - control outputs negated before leaving extended forward mode
// - fault disable at bit 4; when 0, error falling edge interrupts
// - fault disable 1 to 0 with error low interrupts immediately
// - dma flag at bit 3 moves fifo data over drq/dack/tc
// - dma flag 0 tri-states drq; data moves by programmed i/o
// - tc interrupt only with service flag 0; dma write 0 clears it
// - service flag 1 suppresses fifo request, error and tc interrupts
// - service condition with flag 0 sets flag and interrupts host
// - tc is service condition; cleared by mode 000/001 or dma off
// - forward, no dma: threshold of free space is service condition
// - reverse, no dma: threshold of waiting bytes is service condition
// - overrun/underrun is service condition, empty and full read 1
// - mode 011 runs ecp protocol forward, fills fifo in reverse
// - irq driven only with ack enable or mode 010, 011, 110
`timescale 1ns/1ps
`include "ecp_defines.vh"
module ecp_extended_control_logic
#(
   parameter FIFO_DEPTH = `FIFO_DEPTH_DEF,
   parameter CNT_W      = `FIFO_CNT_W_DEF,
   parameter THRESH_W   = `THRESH_W_DEF
)
(
   input  wire                clk_in,
   input  wire                reset_in,
   input  wire                epc_sel_in,
   input  wire                host_wr_in,
   input  wire                host_rd_in,
   input  wire [7:0]          host_wdata_in,
   output wire [7:0]          host_rdata_out,
   input  wire                dir_wr_in,
   input  wire                dir_val_in,
   input  wire                thresh_wr_in,
   input  wire [THRESH_W-1:0] thresh_val_in,
   input  wire                ack_irq_on_in,
   input  wire                err_n_in,
   input  wire                tc_in,
   input  wire                dack_in,
   input  wire [CNT_W-1:0]    fifo_count_in,
   input  wire                fifo_overrun_in,
   input  wire                fifo_underrun_in,
   output wire [2:0]          mode_out,
   output wire                dir_out,
   output wire [THRESH_W-1:0] thresh_out,
   output wire                fifo_reset_out,
   output wire                fifo_host_access_out,
   output wire                auto_xfer_out,
   output wire                ecp_protocol_out,
   output wire                compat_fifo_out,
   output wire                data_drive_out,
   output wire                ctrl_negate_out,
   output wire                cfg_access_out,
   output wire                drq_out,
   output wire                drq_oe_out,
   output wire                irq_out,
   output wire                irq_oe_out
);

   // state of the mode-change sequencer
   localparam ST_IDLE   = 1'b0;
   localparam ST_NEGATE = 1'b1;

   // true for the two programmed i/o modes
   function is_pio;
      input [2:0] m;
      begin
         is_pio = (m == `MODE_COMPAT) | (m == `MODE_BIDIR);
      end
   endfunction

   // true for the two modes with hardware handshake
   function is_auto;
      input [2:0] m;
      begin
         is_auto = (m == `MODE_COMPAT_FIFO) | (m == `MODE_ECP);
      end
   endfunction

   reg [2:0]          mode_q;
   reg [2:0]          mode_d;
   reg [2:0]          pend_mode_q;
   reg                state_q;
   reg                state_d;
   reg                fault_dis_q;
   reg                dma_on_q;
   reg                svc_flag_q;
   reg                dir_q;
   reg [THRESH_W-1:0] thresh_q;
   reg                fifo_err_q;
   reg                tc_pend_q;
   reg                fifo_pend_q;
   reg                fifo_reset_q;
   reg [7:0]          rdata_q;
   reg                tc_q;

   wire               epc_wr;
   wire               epc_rd;
   wire [2:0]         wr_mode;
   wire               mode_ok;
   wire               to_pio;
   wire               leave_fwd;
   wire               mode_to_pio;
   wire               dma_off_wr;
   wire [CNT_W:0]     free_cnt;
   wire [CNT_W:0]     thresh_ext;
   wire               thr_fwd;
   wire               thr_rev;
   wire               fifo_evt;
   wire               tc_evt;
   wire               svc_evt;
   wire               full_flag;
   wire               empty_flag;
   wire               fault_pend;
   wire               auto_mode;

   assign epc_wr  = epc_sel_in & host_wr_in;
   assign epc_rd  = epc_sel_in & host_rd_in;
   assign wr_mode = host_wdata_in[`EPC_MODE_HI:`EPC_MODE_LO];

   // a mode write is honoured only from pio, or when it returns to pio
   assign mode_ok = is_pio(mode_q) | is_pio(wr_mode);
   assign to_pio  = epc_wr & mode_ok & is_pio(wr_mode) & (state_q == ST_IDLE);

   // forward auto mode must drop its control lines before the switch
   assign leave_fwd = to_pio & is_auto(mode_q) & ~dir_q;

   // the cycle in which the mode field actually lands in pio
   assign mode_to_pio = (to_pio & ~leave_fwd) | (state_q == ST_NEGATE);
   assign dma_off_wr  = epc_wr & ~host_wdata_in[`EPC_DMA_BIT];

   // mode-change sequencer
   always @*
   begin
      mode_d  = mode_q;
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (leave_fwd)
               state_d = ST_NEGATE;
            else if (epc_wr & mode_ok)
               mode_d = wr_mode;
         end
         ST_NEGATE:
         begin
            mode_d  = pend_mode_q;
            state_d = ST_IDLE;
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // mode, sequencer and pending target
   always @(posedge clk_in)
   begin
      if (reset_in)
      begin
         mode_q      <= `EPC_RESET_MODE;
         pend_mode_q <= `EPC_RESET_MODE;
         state_q     <= ST_IDLE;
      end
      else
      begin
         mode_q  <= mode_d;
         state_q <= state_d;
         if (leave_fwd)
            pend_mode_q <= wr_mode;
      end
   end

   // writable control bits of the register
   always @(posedge clk_in)
   begin
      if (reset_in)
      begin
         fault_dis_q <= `EPC_RESET_FLAG;
         dma_on_q    <= `EPC_RESET_FLAG;
      end
      else if (epc_wr)
      begin
         fault_dis_q <= host_wdata_in[`EPC_FAULT_DIS_BIT];
         dma_on_q    <= host_wdata_in[`EPC_DMA_BIT];
      end
   end

   // direction and threshold are frozen outside the pio modes
   always @(posedge clk_in)
   begin
      if (reset_in)
      begin
         dir_q    <= 1'h0;
         thresh_q <= `THRESH_RESET;
      end
      else if (is_pio(mode_q))
      begin
         if (dir_wr_in)
            dir_q <= dir_val_in;
         if (thresh_wr_in)
            thresh_q <= thresh_val_in;
      end
   end

   // service conditions; free space counts up to the full depth
   assign free_cnt = FIFO_DEPTH[CNT_W:0] - {1'b0, fifo_count_in};
   assign thresh_ext = {{(CNT_W+1-THRESH_W){1'b0}}, thresh_q};
   assign thr_fwd  = ~dir_q & ~dma_on_q & (free_cnt >= thresh_ext);
   assign thr_rev  = dir_q & ~dma_on_q & ({1'b0, fifo_count_in} >= thresh_ext);
   assign fifo_evt = fifo_overrun_in | fifo_underrun_in;

   // threshold checks only matter while the fifo is in use
   assign auto_mode = is_auto(mode_q);
   assign tc_evt    = dma_on_q & tc_in & ~tc_q;
   assign svc_evt   = ~svc_flag_q & (tc_evt | fifo_evt | (auto_mode & (thr_fwd | thr_rev)));

   // service flag: hardware set wins over a host write of 0
   always @(posedge clk_in)
   begin
      if (reset_in)
         svc_flag_q <= `EPC_RESET_FLAG;
      else if (svc_evt)
         svc_flag_q <= 1'h1;
      else if (epc_wr)
         svc_flag_q <= host_wdata_in[`EPC_SVC_BIT];
   end

   // fifo error latch, cleared only by returning to pio
   always @(posedge clk_in)
   begin
      if (reset_in)
         fifo_err_q <= 1'h0;
      else if (fifo_evt)
         fifo_err_q <= 1'h1;
      else if (mode_to_pio)
         fifo_err_q <= 1'h0;
   end

   // tc interrupt pending; the event beats the clear in one cycle
   always @(posedge clk_in)
   begin
      if (reset_in)
      begin
         tc_pend_q <= 1'h0;
         tc_q      <= 1'h0;
      end
      else
      begin
         tc_q <= tc_in;
         if (tc_evt & ~svc_flag_q)
            tc_pend_q <= 1'h1;
         else if (mode_to_pio | dma_off_wr)
            tc_pend_q <= 1'h0;
      end
   end

   // fifo request/error interrupt pending, dropped when host masks
   always @(posedge clk_in)
   begin
      if (reset_in)
         fifo_pend_q <= 1'h0;
      else if (svc_evt & ~tc_evt)
         fifo_pend_q <= 1'h1;
      else if (mode_to_pio | (epc_wr & host_wdata_in[`EPC_SVC_BIT]))
         fifo_pend_q <= 1'h0;
   end

   // one-cycle fifo reset on every entry to pio
   always @(posedge clk_in)
   begin
      if (reset_in)
         fifo_reset_q <= 1'h1;
      else
         fifo_reset_q <= mode_to_pio;
   end

   // error-line interrupt, cleared by a register read
   fault_irq_detect u_fault
   (
      .clk_in     (clk_in),
      .reset_in   (reset_in),
      .err_n_in   (err_n_in),
      .disable_in (fault_dis_q),
      .clear_in   (epc_rd),
      .pend_out   (fault_pend)
   );

   // an overrun or underrun forces both status bits high
   assign full_flag  = fifo_err_q | (fifo_count_in == FIFO_DEPTH[CNT_W-1:0] + {CNT_W{1'b0}}
                       && fifo_count_in != {CNT_W{1'b0}}) | (fifo_count_in >= FIFO_DEPTH[CNT_W-1:0]
                       && FIFO_DEPTH[CNT_W-1:0] != {CNT_W{1'b0}});
   assign empty_flag = fifo_err_q | (fifo_count_in == {CNT_W{1'b0}});

   // read data registered on the read strobe
   always @(posedge clk_in)
   begin
      if (reset_in)
         rdata_q <= 8'h00;
      else if (epc_rd)
         rdata_q <= {mode_q, fault_dis_q, dma_on_q, svc_flag_q, full_flag, empty_flag};
   end

   assign host_rdata_out = rdata_q;
   assign mode_out       = mode_q;
   assign dir_out        = dir_q;
   assign thresh_out     = thresh_q;
   assign fifo_reset_out = fifo_reset_q;

   // fifo reachable by the host in auto modes and in test mode
   assign fifo_host_access_out = auto_mode | (mode_q == `MODE_FIFO_TEST);

   // hardware handshake only in the transfer modes, immediate on entry
   assign auto_xfer_out    = auto_mode & (state_q == ST_IDLE);
   assign ecp_protocol_out = (mode_q == `MODE_ECP) & (state_q == ST_IDLE);
   assign compat_fifo_out  = (mode_q == `MODE_COMPAT_FIFO) & (state_q == ST_IDLE);

   // fifo bytes reach the lines only in forward auto modes, never in test
   assign data_drive_out  = auto_xfer_out & ~dir_q;
   assign ctrl_negate_out = (state_q == ST_NEGATE);
   assign cfg_access_out  = (mode_q == `MODE_CONFIG);

   // dma request: only while enabled; otherwise released to high z
   assign drq_oe_out = dma_on_q;
   assign drq_out    = dma_on_q & auto_mode & ~dack_in & ~fifo_err_q
                       & (dir_q ? ~empty_flag : ~full_flag);

   // irq drive enabled by ack enable or the fifo modes
   assign irq_oe_out = ack_irq_on_in | auto_mode | (mode_q == `MODE_FIFO_TEST);
   assign irq_out    = irq_oe_out & (fault_pend | tc_pend_q | fifo_pend_q);

endmodule // ecp_extended_control_logic

// [testbench/ecp_ctl_properties.sv]
// Purpose: port-level properties of the extended control logic
// Assumes: one clock, synchronous active-high reset
// Notes:   sees top-level ports only; bound after the module
`timescale 1ns/1ps
`include "ecp_defines.vh"
module ecp_ctl_properties
#(
   parameter THRESH_W = `THRESH_W_DEF
)
(
   input wire                clk_in,
   input wire                reset_in,
   input wire                epc_sel_in,
   input wire                host_wr_in,
   input wire [7:0]          host_wdata_in,
   input wire                ack_irq_on_in,
   input wire [2:0]          mode_out,
   input wire                dir_out,
   input wire [THRESH_W-1:0] thresh_out,
   input wire                fifo_reset_out,
   input wire                fifo_host_access_out,
   input wire                auto_xfer_out,
   input wire                data_drive_out,
   input wire                ctrl_negate_out,
   input wire                cfg_access_out,
   input wire                drq_oe_out,
   input wire                irq_oe_out
);
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (reset_in);
   // a register write as seen at the pins
   wire epc_wr = epc_sel_in & host_wr_in;
   // forward auto mode followed by a pio mode one cycle later
   sequence fwd_leave;
      (mode_out == `MODE_ECP || mode_out == `MODE_COMPAT_FIFO) && !dir_out
         ##1 mode_out < 3'h2;
   endsequence
   chk_test_quiet: assert property (
      mode_out == `MODE_FIFO_TEST |-> fifo_host_access_out && !data_drive_out)
      else $error("fifo test mode drives data or blocks host");
   chk_cfg_open: assert property (
      cfg_access_out == (mode_out == `MODE_CONFIG))
      else $error("config access does not follow mode");
   chk_auto_start: assert property (
      epc_wr && host_wdata_in[7:5] == `MODE_ECP && mode_out < 3'h2
         |=> mode_out == `MODE_ECP && auto_xfer_out)
      else $error("ecp mode write did not start transfer");
   chk_mode_lock: assert property (
      $past(mode_out) > 3'h1 && mode_out != $past(mode_out) |-> mode_out < 3'h2)
      else $error("mode left a non-pio mode for a non-pio mode");
   chk_dir_lock: assert property (
      $past(mode_out) > 3'h1 |-> $stable(dir_out) && $stable(thresh_out))
      else $error("direction or threshold changed outside pio");
   chk_pio_fifo_reset: assert property (
      $past(mode_out) > 3'h1 && mode_out < 3'h2 |-> ##[0:1] fifo_reset_out)
      else $error("no fifo reset on entering pio");
   chk_negate_first: assert property (
      fwd_leave |-> $past(ctrl_negate_out))
      else $error("forward exit without control negation");
   chk_negate_step: assert property (
      $rose(ctrl_negate_out) |-> !auto_xfer_out ##1 mode_out < 3'h2)
      else $error("negation cycle not followed by pio mode");
   chk_drq_float: assert property (
      epc_wr && !host_wdata_in[3] |=> !drq_oe_out)
      else $error("dma request still driven with dma off");
   chk_irq_drive: assert property (
      irq_oe_out == (ack_irq_on_in || mode_out == `MODE_COMPAT_FIFO
         || mode_out == `MODE_ECP || mode_out == `MODE_FIFO_TEST))
      else $error("irq drive enable wrong");
   chk_rsvd_idle: assert property (
      mode_out == `MODE_RSVD_A || mode_out == `MODE_RSVD_B
         |-> !auto_xfer_out && !data_drive_out)
      else $error("reserved mode not idle");
endmodule // ecp_ctl_properties

bind ecp_extended_control_logic ecp_ctl_properties #(.THRESH_W(THRESH_W))
   ecp_ctl_properties_inst (.clk_in(clk_in), .reset_in(reset_in),
   .epc_sel_in(epc_sel_in), .host_wr_in(host_wr_in), .host_wdata_in(host_wdata_in),
   .ack_irq_on_in(ack_irq_on_in), .mode_out(mode_out), .dir_out(dir_out),
   .thresh_out(thresh_out), .fifo_reset_out(fifo_reset_out),
   .fifo_host_access_out(fifo_host_access_out), .auto_xfer_out(auto_xfer_out),
   .data_drive_out(data_drive_out), .ctrl_negate_out(ctrl_negate_out),
   .cfg_access_out(cfg_access_out), .drq_oe_out(drq_oe_out), .irq_oe_out(irq_oe_out));

// [testbench/fifo_peer_model.sv]
// Purpose: host dma channel and fifo fill level behind the port
// Assumes: request already gated by its output enable
// Notes:   slow_in delays each acknowledge by one cycle
`timescale 1ns/1ps
module fifo_peer_model
#(
   parameter DEPTH = 16
)
(
   input  wire       clk_in,
   input  wire       reset_in,
   input  wire       fifo_reset_in,
   input  wire       drq_in,
   input  wire       slow_in,
   output reg        dack_out,
   output reg  [4:0] count_out
);
   reg wait_q;
   // acknowledge one byte per request; fifo level counts them
   always @(posedge clk_in)
   begin
      wait_q   <= drq_in && slow_in && !wait_q && !reset_in;
      dack_out <= drq_in && !dack_out && (!slow_in || wait_q) && !reset_in;
      if (fifo_reset_in)
         count_out <= 5'h00;
      else if (dack_out && count_out < DEPTH)
         count_out <= count_out + 5'h01;
   end
endmodule // fifo_peer_model

// [testbench/testbench.sv]
// Purpose: register-level regression of the extended control logic
// Assumes: 25 MHz clock, synchronous reset held 16 cycles
// Notes:   status bits 1:0 masked except after a fifo error
`timescale 1ns/1ps
module testbench;
   reg        clk_in;
   reg        reset_in;
   reg        sel, hw, hr, dwr, dval, twr, ack, err_n, tc, ovr, slow;
   reg  [7:0] wd;
   reg  [3:0] tval;
   reg  [3:0] m;
   integer    failures;
   integer    tests_run;
   wire [7:0] rdata;
   wire [2:0] mode;
   wire [3:0] thr;
   wire [4:0] cnt;
   wire       dir, frst, fha, ax, ecp, cfo, ddr, neg, cfg, drq, drq_oe, irq, irq_oe, dack;

   ecp_extended_control_logic ecp_extended_control_logic_inst (
      .clk_in(clk_in), .reset_in(reset_in), .epc_sel_in(sel), .host_wr_in(hw),
      .host_rd_in(hr), .host_wdata_in(wd), .host_rdata_out(rdata), .dir_wr_in(dwr),
      .dir_val_in(dval), .thresh_wr_in(twr), .thresh_val_in(tval), .ack_irq_on_in(ack),
      .err_n_in(err_n), .tc_in(tc), .dack_in(dack), .fifo_count_in(cnt),
      .fifo_overrun_in(ovr), .fifo_underrun_in(1'b0), .mode_out(mode), .dir_out(dir),
      .thresh_out(thr), .fifo_reset_out(frst), .fifo_host_access_out(fha),
      .auto_xfer_out(ax), .ecp_protocol_out(ecp), .compat_fifo_out(cfo),
      .data_drive_out(ddr), .ctrl_negate_out(neg), .cfg_access_out(cfg),
      .drq_out(drq), .drq_oe_out(drq_oe), .irq_out(irq), .irq_oe_out(irq_oe));

   fifo_peer_model fifo_peer_model_inst (
      .clk_in(clk_in), .reset_in(reset_in), .fifo_reset_in(frst),
      .drq_in(drq & drq_oe), .slow_in(slow), .dack_out(dack), .count_out(cnt));

   // 40 ns clock
   initial
   begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   task chk(input [7:0] seen, input [7:0] exp, input [63:0] nm);
   begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
      end
   end
   endtask

   task cyc(input integer n);
   begin
      repeat (n) @(posedge clk_in);
      #1;
   end
   endtask

   // register write; returns just after the taking edge
   task put(input [7:0] d);
   begin
      @(posedge clk_in);
      sel <= 1'b1;
      hw  <= 1'b1;
      wd  <= d;
      @(posedge clk_in);
      sel <= 1'b0;
      hw  <= 1'b0;
      #1;
   end
   endtask

   // register read; data sampled a full cycle after the strobe is taken
   task get(input [7:0] msk, input [7:0] exp, input [63:0] nm);
   begin
      @(posedge clk_in);
      sel <= 1'b1;
      hr  <= 1'b1;
      @(posedge clk_in);
      sel <= 1'b0;
      hr  <= 1'b0;
      cyc(1);
      chk(rdata & msk, exp, nm);
   end
   endtask

   task dt(input d, input [3:0] t);
   begin
      @(posedge clk_in);
      dwr  <= 1'b1;
      dval <= d;
      twr  <= 1'b1;
      tval <= t;
      @(posedge clk_in);
      dwr  <= 1'b0;
      twr  <= 1'b0;
      cyc(1);
   end
   endtask

   // one-cycle pulse on tc (which 1) or overrun (which 0)
   task pulse(input which);
   begin
      @(posedge clk_in);
      if (which)
         tc <= 1'b1;
      else
         ovr <= 1'b1;
      @(posedge clk_in);
      tc  <= 1'b0;
      ovr <= 1'b0;
      cyc(2);
   end
   endtask

   task results;
   begin
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask

   // run is well under two hundred cycles; this bound only catches a hang
   initial
   begin
      repeat (4000) @(posedge clk_in);
      failures = failures + 1;
      results;
   end

   initial
   begin
      {sel, hw, hr, dwr, dval, twr, ack, tc, ovr, slow} = 10'h000;
      err_n = 1'b1;
      wd = 8'h00;
      tval = 4'h0;
      failures = 0;
      tests_run = 0;
      reset_in = 1'b1;
      repeat (16) @(posedge clk_in);
      reset_in <= 1'b0;
      cyc(1);
      chk(thr, 8'h08, "thresh");
      get(8'hFC, 8'h00, "epc_rst");
      dt(1'b1, 4'h5);
      chk({dir, thr}, 8'h15, "dirthr");
      put(8'h64);
      chk({mode, ax, ecp}, 8'h0F, "ecp");
      dt(1'b0, 4'h2);
      chk({dir, thr}, 8'h15, "dirlock");
      put(8'hC4);
      chk(mode, 8'h03, "modelock");
      put(8'h04);
      cyc(1);
      chk(mode, 8'h00, "topio");
      dt(1'b0, 4'h5);
      // each mode 010 to 111 from pio and back; service flag held to keep irq quiet
      for (m = 4'h2; m < 4'h8; m = m + 4'h1)
      begin
         put({m[2:0], 5'h04});
         chk(mode, m, "mode");
         chk(ax, m < 4, "auto");
         chk(cfg, m == 7, "cfg");
         chk(irq_oe, m == 2 || m == 3 || m == 6, "irqoe");
         chk(ddr, m < 4, "drive");
         chk(cfo, m == 2, "compat");
         if (m == 6) chk(fha, 8'h01, "fifoacc");
         put(8'h04);
         chk(neg, m < 4, "negate");
         // the negation cycle delays both the switch and the fifo reset by one
         if (m < 4)
            cyc(1);
         chk({mode, frst}, 8'h01, "pio_rst");
      end
      @(posedge clk_in) ack <= 1'b1;
      @(posedge clk_in) err_n <= 1'b0;
      cyc(3);
      chk(irq, 8'h01, "fault");
      get(8'h10, 8'h00, "fdis");
      chk(irq, 8'h00, "faultclr");
      put(8'h14);
      @(posedge clk_in) err_n <= 1'b1;
      @(posedge clk_in) err_n <= 1'b0;
      cyc(3);
      chk(irq, 8'h00, "faultoff");
      put(8'h04);
      cyc(1);
      chk(irq, 8'h01, "fault_en");
      get(8'h10, 8'h00, "ack_read");
      @(posedge clk_in) err_n <= 1'b1;
      put(8'h68);
      chk(drq_oe, 8'h01, "drq_oe");
      cyc(6);
      chk(cnt != 0, 8'h01, "dmamove");
      pulse(1'b1);
      chk(irq, 8'h01, "tc_irq");
      get(8'h04, 8'h04, "svcflag");
      put(8'h64);
      cyc(1);
      chk({irq, drq_oe}, 8'h00, "tc_clr");
      @(posedge clk_in) slow <= 1'b1;
      put(8'h6C);
      pulse(1'b1);
      chk(irq, 8'h00, "svc_mask");
      // leaves with bytes still queued on purpose, to see the reset clear them
      put(8'h04);
      cyc(3);
      chk(cnt, 8'h00, "fifoclr");
      put(8'h00);
      pulse(1'b0);
      chk(irq, 8'h01, "ovr_irq");
      get(8'h07, 8'h07, "ovr_stat");
      put(8'h04);
      cyc(2);
      chk(irq, 8'h00, "ovr_clr");
      results;
   end
endmodule // testbench
